// ---- logic/loop_cfg_pkg.sv ----
package loop_cfg_pkg;
   // Register offsets
   localparam logic [11:0] ADDR_CONFIG    = 12'h000;
   localparam logic [11:0] ADDR_READBACK  = 12'h004;
   localparam logic [11:0] ADDR_TAG_LO    = 12'h005;
   localparam logic [11:0] ADDR_TAG_HI    = 12'h006;
   localparam logic [11:0] ADDR_PRI_LO    = 12'h010;
   localparam logic [11:0] ADDR_PRI_HI    = 12'h011;
   localparam logic [11:0] ADDR_SEC_LO    = 12'h012;
   localparam logic [11:0] ADDR_SEC_HI    = 12'h013;
   localparam logic [11:0] ADDR_TEST      = 12'h014;
   localparam logic [11:0] ADDR_RSVD      = 12'h015;
   localparam logic [11:0] ADDR_FB_LO     = 12'h016;
   localparam logic [11:0] ADDR_FB_HI     = 12'h017;
   // Field positions
   localparam int SOFT_RESET_BIT  = 5;
   localparam int READBACK_BIT    = 0;
   localparam int DIV_HI_BITS     = 2;
   localparam int TEST_DIV_BITS   = 6;
   // Reset values
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [9:0] DIV10_RESET  = 10'h001;
   localparam logic [5:0] DIV6_RESET   = 6'h01;
   localparam int NUM_DIVIDERS = 4;

   typedef struct packed {
      logic [7:0] config_b;
      logic [7:0] readback;
      logic [7:0] tagLo;
      logic [7:0] tagHi;
      logic [9:0] priDiv;
      logic [9:0] secDiv;
      logic [5:0] testDiv;
      logic [9:0] fbDiv;
   } reg_set_t;

   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  data;
   } reg_req_t;
endpackage

// ---- logic/clock_divider.sv ----
`timescale 1ns/1ns
module clock_divider
   import loop_cfg_pkg::*;
(
   input  wire logic       clk_sys,  // System clock
   input  wire logic       nrst,     // Async reset, active low
   input  wire logic       clkIn,    // Divider input clock (sync level)
   input  wire logic [9:0] divValue, // Active divide ratio
   output logic            divPulse  // One pulse per ratio edges
);
   logic       clkInDly_q;
   logic [9:0] count_q;
   logic [9:0] count_d;
   logic [9:0] lastDiv_q;
   logic [9:0] ratio;
   logic       rise;
   logic       hit;
   logic       divPulse_d;

   // Zero behaves as one
   assign ratio      = (divValue == 10'h000) ? 10'h001 : divValue;        // [RQ8] [RQ11]
   assign rise       = clkIn & ~clkInDly_q;
   assign hit        = rise && (count_q + 10'h001 >= ratio);
   assign count_d    = (divValue != lastDiv_q) ? 10'h000 :
                       hit ? 10'h000 : rise ? count_q + 10'h001 : count_q; // [RQ13]
   assign divPulse_d = (divValue == lastDiv_q) && hit;                    // [RQ13]

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         clkInDly_q <= 1'b0;
         count_q    <= 10'h000;
         lastDiv_q  <= 10'h001;
         divPulse   <= 1'b0;
      end
      else
      begin
         clkInDly_q <= clkIn;
         count_q    <= count_d;
         lastDiv_q  <= divValue;
         divPulse   <= divPulse_d;
      end
   end
endmodule // clock_divider

// ---- logic/input_loop_divider_config_regs.sv ----
`timescale 1ns/1ns
// Overview of operation
// RQ1: Config bit 5 resets registers, self-clears.
// RQ2: Host mirrors config nibbles when writing.
// RQ3: Readback select zero returns active values.
// RQ4: Readback select one returns staged values.
// RQ5: Sixteen-bit version tag at two bytes.
// RQ6: Tag resets zero, writable, affects nothing.
// RQ7: Primary divider ten bits, low/high bytes.
// RQ8: Zero divides by one, else programmed.
// RQ9: Secondary divider ten bits, same encoding.
// RQ10: Secondary independent only with enable set.
// RQ11: Test divider six bits, zero is one.
// RQ12: Feedback divider ten bits, two bytes.
// RQ13: Dividers count edges, restart on change.
// RQ14: Reserved bits read zero, ignore writes.
module input_loop_divider_config_regs
   import loop_cfg_pkg::*;
(
   input  wire logic       clk_sys,       // System clock, 100 MHz
   input  wire logic       nrst,          // Async reset, active low
   input  wire logic       regWr,         // Write strobe, one cycle
   input  wire logic       regRd,         // Read strobe, one cycle
   input  wire logic [11:0] regAddr,      // Register byte address
   input  wire logic [7:0] regWdata,      // Write data
   output logic      [7:0] regRdata,      // Read data, registered
   output logic            regRvalid,     // Read data valid pulse
   input  wire logic       ioUpdate,      // Staged to active transfer pulse
   input  wire logic       secIndepEn,    // Secondary independent enable
   input  wire logic       primaryRefClk, // Primary reference input
   input  wire logic       secondaryRefClk, // Secondary reference input
   input  wire logic       testRefClk,    // Test reference input
   input  wire logic       feedbackClk,   // Loop feedback input
   output logic            primaryDivOut,   // Primary divided pulse
   output logic            secondaryDivOut, // Secondary divided pulse
   output logic            testDivOut,      // Test divided pulse
   output logic            feedbackDivOut,  // Feedback divided pulse
   output logic [15:0]     userVersionTag,  // Version tag value
   output logic            softResetBusy    // Soft reset in progress
);
   // ==============================================================
   // Register state
   reg_set_t stage_q;
   reg_set_t stage_d;
   reg_set_t active_q;
   reg_set_t active_d;
   logic     softRst_q;
   logic     softRst_d;
   reg_req_t req;

   assign req = '{wr: regWr, addr: regAddr, data: regWdata};

   // ==============================================================
   // Write decode
   wire wrCfg  = req.wr && (req.addr == ADDR_CONFIG);
   wire wrRb   = req.wr && (req.addr == ADDR_READBACK);
   wire wrTagL = req.wr && (req.addr == ADDR_TAG_LO);
   wire wrTagH = req.wr && (req.addr == ADDR_TAG_HI);
   wire wrPriL = req.wr && (req.addr == ADDR_PRI_LO);
   wire wrPriH = req.wr && (req.addr == ADDR_PRI_HI);
   wire wrSecL = req.wr && (req.addr == ADDR_SEC_LO);
   wire wrSecH = req.wr && (req.addr == ADDR_SEC_HI);
   wire wrTest = req.wr && (req.addr == ADDR_TEST);
   wire wrFbL  = req.wr && (req.addr == ADDR_FB_LO);
   wire wrFbH  = req.wr && (req.addr == ADDR_FB_HI);
   wire softRstReq = wrCfg && req.data[SOFT_RESET_BIT];                  // [RQ1]

   // Bit 5 is not stored: it only fires the reset and reads back zero
   wire [7:0] cfgWr = req.data & ~(8'h01 << SOFT_RESET_BIT);

   always_comb
   begin
      stage_d = stage_q;
      if (wrCfg)
         stage_d.config_b = cfgWr;
      if (wrRb)
         stage_d.readback = {7'h00, req.data[READBACK_BIT]};              // [RQ14]
      if (wrTagL)
         stage_d.tagLo = req.data;                                         // [RQ5] [RQ6]
      if (wrTagH)
         stage_d.tagHi = req.data;                                         // [RQ5] [RQ6]
      if (wrPriL)
         stage_d.priDiv[7:0] = req.data;                                   // [RQ7]
      if (wrPriH)
         stage_d.priDiv[9:8] = req.data[DIV_HI_BITS-1:0];                  // [RQ7] [RQ14]
      if (wrSecL)
         stage_d.secDiv[7:0] = req.data;                                   // [RQ9]
      if (wrSecH)
         stage_d.secDiv[9:8] = req.data[DIV_HI_BITS-1:0];                  // [RQ9] [RQ14]
      if (wrTest)
         stage_d.testDiv = req.data[TEST_DIV_BITS-1:0];                    // [RQ11] [RQ14]
      if (wrFbL)
         stage_d.fbDiv[7:0] = req.data;                                    // [RQ12]
      if (wrFbH)
         stage_d.fbDiv[9:8] = req.data[DIV_HI_BITS-1:0];                   // [RQ12] [RQ14]
   end

   // Serial-port config and readback select act at once; the rest wait
   always_comb
   begin
      active_d          = ioUpdate ? stage_d : active_q;                   // [RQ4]
      active_d.config_b = stage_d.config_b;
      active_d.readback = stage_d.readback;
   end

   function automatic reg_set_t defaults();
      reg_set_t v;
      v          = '0;
      v.config_b = CONFIG_RESET;
      v.readback = BYTE_RESET;
      v.tagLo    = BYTE_RESET;
      v.tagHi    = BYTE_RESET;
      v.priDiv   = DIV10_RESET;
      v.secDiv   = DIV10_RESET;
      v.testDiv  = DIV6_RESET;
      v.fbDiv    = DIV10_RESET;
      return v;
   endfunction

   assign softRst_d = softRstReq;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_q   <= '{config_b: CONFIG_RESET, readback: BYTE_RESET, tagLo: BYTE_RESET,
                        tagHi: BYTE_RESET, priDiv: DIV10_RESET, secDiv: DIV10_RESET,
                        testDiv: DIV6_RESET, fbDiv: DIV10_RESET};
         active_q  <= '{config_b: CONFIG_RESET, readback: BYTE_RESET, tagLo: BYTE_RESET,
                        tagHi: BYTE_RESET, priDiv: DIV10_RESET, secDiv: DIV10_RESET,
                        testDiv: DIV6_RESET, fbDiv: DIV10_RESET};
         softRst_q <= 1'b0;
      end
      else if (softRstReq)
      begin
         stage_q   <= defaults();                                          // [RQ1]
         active_q  <= defaults();                                          // [RQ1]
         softRst_q <= softRst_d;
      end
      else
      begin
         stage_q   <= stage_d;
         active_q  <= active_d;
         softRst_q <= softRst_d;
      end
   end

   assign softResetBusy = softRst_q;

   // ==============================================================
   // Readback
   wire       readStaged = active_q.readback[READBACK_BIT];
   reg_set_t  view;
   assign view = readStaged ? stage_q : active_q;                         // [RQ3] [RQ4]

   logic [7:0] rdMux;
   always_comb
   begin
      case (regAddr)
         ADDR_CONFIG:   rdMux = active_q.config_b;
         ADDR_READBACK: rdMux = active_q.readback;
         ADDR_TAG_LO:   rdMux = view.tagLo;
         ADDR_TAG_HI:   rdMux = view.tagHi;
         ADDR_PRI_LO:   rdMux = view.priDiv[7:0];
         ADDR_PRI_HI:   rdMux = {6'h00, view.priDiv[9:8]};                // [RQ14]
         ADDR_SEC_LO:   rdMux = view.secDiv[7:0];
         ADDR_SEC_HI:   rdMux = {6'h00, view.secDiv[9:8]};                // [RQ14]
         ADDR_TEST:     rdMux = {2'h0, view.testDiv};                     // [RQ14]
         ADDR_RSVD:     rdMux = 8'h00;                                    // [RQ14]
         ADDR_FB_LO:    rdMux = view.fbDiv[7:0];
         ADDR_FB_HI:    rdMux = {6'h00, view.fbDiv[9:8]};                 // [RQ14]
         default:       rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         regRdata  <= 8'h00;
         regRvalid <= 1'b0;
      end
      else
      begin
         regRdata  <= regRd ? rdMux : regRdata;
         regRvalid <= regRd;
      end
   end

   // Tag feeds nothing but this output and the register readback
   assign userVersionTag = {active_q.tagHi, active_q.tagLo};              // [RQ6]

   // ==============================================================
   // Dividers
   logic [NUM_DIVIDERS-1:0] divIn;
   logic [9:0]              divRatio [NUM_DIVIDERS];
   logic [NUM_DIVIDERS-1:0] divOut;

   // Without the enable the secondary path follows the primary ratio
   wire [9:0] secRatio = secIndepEn ? active_q.secDiv : active_q.priDiv; // [RQ10]

   assign divIn       = {feedbackClk, testRefClk, secondaryRefClk, primaryRefClk};
   assign divRatio[0] = active_q.priDiv;                                  // [RQ7]
   assign divRatio[1] = secRatio;                                         // [RQ9]
   assign divRatio[2] = {4'h0, active_q.testDiv};                         // [RQ11]
   assign divRatio[3] = active_q.fbDiv;                                   // [RQ12]

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DIVIDERS; gi++)
      begin : g_div
         clock_divider u_div (
            .clk_sys  (clk_sys),
            .nrst     (nrst),
            .clkIn    (divIn[gi]),
            .divValue (divRatio[gi]),
            .divPulse (divOut[gi])
         );
      end
   endgenerate

   assign primaryDivOut   = divOut[0];
   assign secondaryDivOut = divOut[1];
   assign testDivOut      = divOut[2];
   assign feedbackDivOut  = divOut[3];
endmodule // input_loop_divider_config_regs

// ---- sim/loop_cfg_props.sv ----
`timescale 1ns/1ns
// ==========
// Port checks
module loop_cfg_props
   import loop_cfg_pkg::*;
(
   input wire logic        clk_sys,        // Clock
   input wire logic        nrst,           // Reset
   input wire logic        regWr,          // Write strobe
   input wire logic        regRd,          // Read strobe
   input wire logic [11:0] regAddr,        // Address
   input wire logic [7:0]  regWdata,       // Write data
   input wire logic [7:0]  regRdata,       // Read data
   input wire logic        regRvalid,      // Read valid
   input wire logic        ioUpdate,       // Transfer pulse
   input wire logic [15:0] userVersionTag, // Tag
   input wire logic        softResetBusy   // Soft reset flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence softRst;
      regWr && regAddr == ADDR_CONFIG && regWdata[SOFT_RESET_BIT];
   endsequence
   sequence rdAt(logic [11:0] a);
      regRd && regAddr == a;
   endsequence
   read_answer_a: assert property (regRd |=> regRvalid)
      else $error("read not answered");
   valid_cause_a: assert property (regRvalid |-> $past(regRd))
      else $error("valid without read");
   soft_busy_a: assert property (softRst |=> softResetBusy)
      else $error("soft reset flag missing");
   soft_tag_a: assert property (softRst |=> userVersionTag == 16'h0000)
      else $error("tag not cleared");
   tag_cause_a: assert property ($changed(userVersionTag) |->
      $past(ioUpdate) || $past(regWr && regAddr == ADDR_CONFIG && regWdata[SOFT_RESET_BIT]))
      else $error("tag changed without cause");
   rsvd_zero_a: assert property (rdAt(ADDR_RSVD) |=> regRdata == 8'h00)
      else $error("reserved byte not zero");
   test_top_a: assert property (rdAt(ADDR_TEST) |=> regRdata[7:6] == 2'h0)
      else $error("test divider top bits set");
   pri_hi_a: assert property (rdAt(ADDR_PRI_HI) |=> regRdata[7:2] == 6'h00)
      else $error("primary high bits set");
   fb_hi_a: assert property (rdAt(ADDR_FB_HI) |=> regRdata[7:2] == 6'h00)
      else $error("feedback high bits set");
   cfg_bit5_a: assert property (rdAt(ADDR_CONFIG) |=> !regRdata[5])
      else $error("soft reset bit not self clearing");
endmodule // loop_cfg_props

bind input_loop_divider_config_regs loop_cfg_props chk (.clk_sys(clk_sys), .nrst(nrst),
   .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .regRvalid(regRvalid), .ioUpdate(ioUpdate),
   .userVersionTag(userVersionTag), .softResetBusy(softResetBusy));

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
// ==========
// Host on the control port
module host_model
   import loop_cfg_pkg::*;
(
   input  wire logic        clk_sys,   // Clock
   output logic             regWr,     // Write strobe
   output logic             regRd,     // Read strobe
   output logic [11:0]      regAddr,   // Address
   output logic [7:0]       regWdata,  // Write data
   input  wire logic [7:0]  regRdata,  // Read data
   input  wire logic        regRvalid  // Read valid
);
   initial
   begin
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 12'hFFF;
      regWdata = 8'h00;
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      // Released data is scrambled so stale values never look valid
      regWdata <= ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d, output bit ok);
      ok = 0;
      d = 8'hXX;
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      repeat (4)
      begin
         @(posedge clk_sys);
         if (!ok && regRvalid === 1'b1)
         begin
            d = regRdata;
            ok = 1;
         end
      end
   endtask
   task automatic cfg(input logic [3:0] hi);
      wr(ADDR_CONFIG, {hi, hi[0], hi[1], hi[2], hi[3]});
   endtask
endmodule // host_model

// ---- sim/test_input_loop_divider_config_regs.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %0h seen %0h", n, e, s); end end
// ==========
// Bench
module test_input_loop_divider_config_regs;
   import loop_cfg_pkg::*;
   typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] s; logic [7:0] d;} row_t;
   logic clk_sys, nrst, regWr, regRd, regRvalid, ioUpdate, secIndepEn, softResetBusy;
   logic [11:0] regAddr;
   logic [7:0]  regWdata, regRdata, v;
   logic [3:0]  refClk, divOut;
   logic [15:0] userVersionTag;
   int mismatches, tests_run, cnt[5];
   int exp1[4] = '{3, 5, 3, 15};
   bit ok;
   row_t rows[10] = '{'{ADDR_TAG_LO, 8'hA5, 8'hA5, 8'h00}, '{ADDR_TAG_HI, 8'h3C, 8'h3C, 8'h00},
      '{ADDR_PRI_LO, 8'h05, 8'h05, 8'h01}, '{ADDR_PRI_HI, 8'hFC, 8'h00, 8'h00},
      '{ADDR_SEC_LO, 8'h03, 8'h03, 8'h01}, '{ADDR_SEC_HI, 8'h04, 8'h00, 8'h00},
      '{ADDR_TEST, 8'hC4, 8'h04, 8'h01}, '{ADDR_RSVD, 8'hFF, 8'h00, 8'h00},
      '{ADDR_FB_LO, 8'h00, 8'h00, 8'h01}, '{ADDR_FB_HI, 8'h00, 8'h00, 8'h00}};
   input_loop_divider_config_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .regWr(regWr),
      .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .regRvalid(regRvalid), .ioUpdate(ioUpdate), .secIndepEn(secIndepEn),
      .primaryRefClk(refClk[0]), .secondaryRefClk(refClk[1]), .testRefClk(refClk[2]),
      .feedbackClk(refClk[3]), .primaryDivOut(divOut[0]), .secondaryDivOut(divOut[1]),
      .testDivOut(divOut[2]), .feedbackDivOut(divOut[3]), .userVersionTag(userVersionTag),
      .softResetBusy(softResetBusy));
   host_model host (.clk_sys(clk_sys), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      foreach (divOut[i]) cnt[i] += int'(divOut[i] === 1'b1);
      cnt[4] += int'(softResetBusy === 1'b1);
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic read(input logic [11:0] a);
      host.rd(a, v, ok);
      if (!ok)
      begin
         mismatches++;
         give_verdict();
      end
   endtask
   // Clock inputs toggle slowly so every edge is seen
   task automatic edges(input int k);
      cnt = '{default: 0};
      repeat (k)
      begin
         @(posedge clk_sys) refClk <= 4'hF;
         @(posedge clk_sys) refClk <= 4'h0;
      end
      repeat (4) @(posedge clk_sys);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      give_verdict();
   end
   initial
   begin
      {nrst, ioUpdate, secIndepEn, refClk, mismatches, tests_run} = '0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      secIndepEn <= 1'b1;
      foreach (rows[i]) host.wr(rows[i].a, rows[i].w);
      for (int p = 0; p < 3; p++)
      begin
         if (p > 0) host.wr(ADDR_READBACK, {7'h00, p == 1});
         if (p == 2)
         begin
            @(posedge clk_sys) ioUpdate <= 1'b1;
            @(posedge clk_sys) ioUpdate <= 1'b0;
         end
         foreach (rows[i])
         begin
            read(rows[i].a);
            `CHK("reg", (p == 0) ? rows[i].d : rows[i].s, v)
         end
      end
      `CHK("tag", 16'h3CA5, userVersionTag)
      read(12'h0FF);
      `CHK("unmapped", 8'h00, v)
      edges(15);
      foreach (exp1[i]) `CHK("div", exp1[i], cnt[i])
      secIndepEn <= 1'b0;
      edges(15);
      `CHK("sec follows", 3, cnt[1])
      host.cfg(4'h2);
      repeat (2) @(posedge clk_sys);
      `CHK("busy", 1, cnt[4])
      `CHK("tag clr", 16'h0000, userVersionTag)
      read(ADDR_TAG_LO);
      `CHK("tag lo", 8'h00, v)
      read(ADDR_CONFIG);
      `CHK("cfg", 1'b0, v[SOFT_RESET_BIT])
      give_verdict();
   end
endmodule // test_input_loop_divider_config_regs
